// [src/pcih_master.sv]
`timescale 1ns/100ps
// =====================================================================
// Write-data buffer
module pcih_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  logic [AW:0]  wp_nxt;
  logic [AW:0]  rp_nxt;
  logic         push;

  // Pointers carry one extra bit so full and empty are told apart.
  always_comb begin
    in_ready  = !((wp_r[AW] != rp_r[AW]) &&
                  (wp_r[AW-1:0] == rp_r[AW-1:0]));
    out_valid = (wp_r != rp_r);
    push      = in_valid && in_ready;
    wp_nxt    = push ? wp_r + 1'b1 : wp_r;
    rp_nxt    = (out_valid && out_ready) ? rp_r + 1'b1 : rp_r;
    out_data  = mem[rp_r[AW-1:0]];
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule : pcih_fifo

// =====================================================================
// Bus master and reset/strap controller facing the device
module pcih_master
  import pcih_pkg::*;
#(
  parameter int RST_LEN = RST_CLKS
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         host_mode,
  input  wire logic         req_valid,
  output logic              req_ready,
  input  wire pcih_req_t    req,
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [31:0]  wr_data,
  output logic              rd_valid,
  output logic [31:0]       rd_data,
  output logic              done,
  output pcih_stat_t        stat,
  output logic              pci_clk,
  output logic              pci_rst_n,
  output logic              host_role_strap_n,
  output logic              idsel,
  input  wire logic [31:0]  ad_i,
  output logic [31:0]       ad_o,
  output logic              ad_oe,
  output logic [3:0]        cbe_n_o,
  output logic              cbe_oe,
  input  wire logic         par_i,
  output logic              par_o,
  output logic              par_oe,
  input  wire logic         frame_n_i,
  output logic              frame_n_o,
  output logic              frame_oe,
  input  wire logic         irdy_n_i,
  output logic              irdy_n_o,
  output logic              irdy_oe,
  input  wire logic         trdy_n_i,
  input  wire logic         devsel_n_i,
  input  wire logic         stop_n_i,
  output logic              lock_n_o,
  output logic              lock_oe,
  output logic              perr_n_o,
  output logic              perr_oe,
  input  wire logic         serr_n_i,
  output logic [AGENTS-1:0] arbiter_request_in_n,
  input  wire logic [AGENTS-1:0] arbiter_grant_out_n,
  input  wire logic         dev_req_n_i,
  output logic              dev_gnt_n
);
  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [31:0]       ad_s;
  logic              par_s, frame_s, irdy_s, trdy_s, devsel_s, stop_s;
  logic              serr_s, dreq_s;
  logic [AGENTS-1:0] gnt_s;
  logic              fifo_valid;
  logic              fifo_pop;
  logic [31:0]       fifo_data;
  logic              pe;
  logic              own;
  logic              ph_done;
  logic              is_wr;

  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             pclk_r, pclk_nxt;
  pcih_state_t      st_r, st_nxt;
  logic [7:0]       rc_r, rc_nxt;
  logic [2:0]       tmo_r, tmo_nxt;
  logic [4:0]       left_r, left_nxt;
  pcih_req_t        q_r, q_nxt;
  pcih_stat_t       stat_r, stat_nxt;
  logic             rst_r, rst_nxt, strap_r, strap_nxt;
  logic             frame_r, frame_nxt, irdy_r, irdy_nxt, bus_oe_r;
  logic             bus_oe_nxt, ad_oe_r, ad_oe_nxt, par_r, par_nxt;
  logic             par_oe_r, par_oe_nxt, idsel_r, idsel_nxt;
  logic             lock_r, lock_nxt, areq_r, areq_nxt;
  logic             dgnt_r, dgnt_nxt, dgh_r, dgh_nxt;
  logic             chk_r, chk_nxt, xd_r, xd_nxt;
  logic             perr_r, perr_nxt, perr_oe_r, perr_oe_nxt;
  logic             rdv_r, rdv_nxt, done_r, done_nxt;
  logic [31:0]      ad_r, ad_nxt, rdd_r, rdd_nxt;
  logic [3:0]       cbe_r, cbe_nxt;

  pcih_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Pins from the device pass two flops; only the second is read.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s1_r <= '1;
      s2_r <= '1;
    end else begin
      s1_r <= {ad_i, par_i, frame_n_i, irdy_n_i, trdy_n_i, devsel_n_i,
               stop_n_i, serr_n_i, arbiter_grant_out_n, dev_req_n_i};
      s2_r <= s1_r;
    end
  end
  assign {ad_s, par_s, frame_s, irdy_s, trdy_s, devsel_s, stop_s,
          serr_s, gnt_s, dreq_s} = s2_r;

  // The step runs one core cycle after the bus-clock rise, so the second
  // sync stage holds pin levels from just before that rise.
  assign pe      = (cnt_r == '0);                        // [RULE1]
  assign is_wr   = q_r.cmd[0];
  assign ph_done = !irdy_r && !trdy_s;                   // [RULE11]
  assign own     = strap_r ? (dgnt_r && dgh_r)
                           : !gnt_s[AGENT_IDX];          // [RULE20]
  assign fifo_pop = pe && (st_r == S_DATA) && is_wr && ph_done;

  // Next-state logic; every bus output except pci_clk and the strap changes only on a step.
  always_comb begin
    cnt_nxt  = (cnt_r == CNT_W'(DIV - 1)) ? '0 : cnt_r + 1'b1;
    pclk_nxt = (cnt_nxt < CNT_W'(HALF));
    st_nxt = st_r;       rc_nxt = rc_r;       tmo_nxt = tmo_r;
    left_nxt = left_r;   q_nxt = q_r;         stat_nxt = stat_r;
    rst_nxt = rst_r;     strap_nxt = strap_r; frame_nxt = frame_r;
    irdy_nxt = irdy_r;   bus_oe_nxt = bus_oe_r; ad_oe_nxt = ad_oe_r;
    par_nxt = par_r;     par_oe_nxt = par_oe_r; idsel_nxt = idsel_r;
    lock_nxt = lock_r;   areq_nxt = areq_r;   dgnt_nxt = dgnt_r;
    dgh_nxt = dgh_r;     chk_nxt = chk_r;     xd_nxt = xd_r;
    perr_nxt = perr_r;   perr_oe_nxt = perr_oe_r;
    ad_nxt = ad_r;       cbe_nxt = cbe_r;     rdd_nxt = rdd_r;
    rdv_nxt = 1'b0;
    done_nxt = 1'b0;
    req_ready = (st_r == S_IDLE) && pe;
    if (st_r == S_RST) begin
      strap_nxt = !host_mode;                            // [RULE4]
    end
    if (pe) begin
      par_nxt    = ^{ad_r, cbe_r};                       // [RULE7]
      par_oe_nxt = ad_oe_r;                              // [RULE8]
      chk_nxt    = 1'b0;
      // Read parity is checked one clock after data; PERR follows. 
      if (chk_r && (par_s != xd_r)) begin
        perr_nxt    = 1'b0;                              // [RULE18]
        perr_oe_nxt = 1'b1;
        stat_nxt.perr = 1'b1;
      end else if (!perr_r) begin
        perr_nxt = 1'b1;
      end else begin
        perr_oe_nxt = 1'b0;
      end
      if (!serr_s && st_r != S_IDLE) begin
        stat_nxt.serr = 1'b1;                            // [RULE19]
      end
      // Satellite role: this end arbitrates and grants the device only
      // while idle; its request is ignored until reset ends.
      dgh_nxt  = dgnt_r;
      dgnt_nxt = !(strap_r && st_r == S_IDLE && !req_valid &&
                   !dreq_s);                             // [RULE16] [RULE17]
      unique case (st_r)
        S_RST: begin
          rc_nxt = rc_r + 1'b1;
          if (rc_r == 8'(RST_LEN - 1)) begin
            rc_nxt  = '0;
            rst_nxt = 1'b1;
            st_nxt  = S_WAKE;
          end
        end
        S_WAKE: begin
          rc_nxt = rc_r + 1'b1;
          if (rc_r == 8'(RESUME_EDGES - 1)) begin          // [RULE2]
            st_nxt = S_IDLE;
          end
        end
        S_IDLE: begin
          if (req_valid) begin
            q_nxt    = req;
            left_nxt = (req.words == '0) ? 5'd1 : req.words;
            stat_nxt = '0;
            areq_nxt = !strap_r;
            st_nxt   = S_REQ;
          end
        end
        S_REQ: begin
          if (own && frame_s && irdy_s) begin            // [RULE22]
            areq_nxt   = 1'b0;
            frame_nxt  = 1'b0;                           // [RULE9]
            bus_oe_nxt = 1'b1;
            ad_oe_nxt  = 1'b1;
            ad_nxt     = q_r.addr;                       // [RULE5]
            cbe_nxt    = q_r.cmd;                        // [RULE6]
            idsel_nxt  = (q_r.cmd[3:1] == CMD_CFG);      // [RULE13]
            lock_nxt   = q_r.lock;                       // [RULE15]
            tmo_nxt    = '0;
            st_nxt     = S_ADDR;
          end
        end
        S_ADDR: begin
          cbe_nxt   = q_r.be_n;                          // [RULE6]
          ad_oe_nxt = is_wr;
          idsel_nxt = 1'b0;
          st_nxt    = S_DATA;
        end
        S_DATA: begin
          if (devsel_s) begin
            tmo_nxt = tmo_r + 1'b1;
          end
          if (ph_done) begin
            left_nxt = left_r - 1'b1;
            if (!is_wr) begin
              rdv_nxt = 1'b1;
              rdd_nxt = ad_s;
              chk_nxt = 1'b1;
              xd_nxt  = ^{ad_s, cbe_r};
            end
          end
          if (devsel_s && tmo_r == 3'(DEVSEL_TMO - 1)) begin
            stat_nxt.abort = 1'b1;                       // [RULE14]
            st_nxt = S_END;
          end else if (frame_r && (ph_done || !stop_s)) begin
            st_nxt = S_END;
          end else if (!stop_s) begin
            frame_nxt = 1'b0 ^ 1'b1;                     // [RULE12]
            irdy_nxt  = 1'b0;
            stat_nxt.stopped = 1'b1;
          end else if (ph_done) begin
            irdy_nxt = 1'b1;
          end else if (irdy_r && (!is_wr || fifo_valid)) begin
            irdy_nxt  = 1'b0;                            // [RULE10]
            frame_nxt = (left_r == 5'd1);                // [RULE9]
            if (is_wr) begin
              ad_nxt = fifo_data;
            end
          end
          if (st_nxt == S_END) begin
            frame_nxt = 1'b1;
            irdy_nxt  = 1'b1;
            ad_oe_nxt = 1'b0;
          end
        end
        S_END: begin
          bus_oe_nxt = 1'b0;
          lock_nxt   = 1'b0;
          done_nxt   = 1'b1;
          st_nxt     = S_IDLE;
        end
      endcase
    end
    if (st_r == S_IDLE && pe && req_valid) begin
      irdy_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_r <= '0;      pclk_r <= 1'b0;    st_r <= S_RST;
      rc_r <= '0;       tmo_r <= '0;       left_r <= '0;
      q_r <= '0;        stat_r <= '0;      rst_r <= 1'b0;
      strap_r <= 1'b1;  frame_r <= 1'b1;   irdy_r <= 1'b1;
      bus_oe_r <= 1'b0; ad_oe_r <= 1'b0;   par_r <= 1'b0;
      par_oe_r <= 1'b0; idsel_r <= 1'b0;   lock_r <= 1'b0;
      areq_r <= 1'b0;   dgnt_r <= 1'b1;    dgh_r <= 1'b1;
      chk_r <= 1'b0;    xd_r <= 1'b0;      perr_r <= 1'b1;
      perr_oe_r <= 1'b0; rdv_r <= 1'b0;    done_r <= 1'b0;
      ad_r <= '0;       cbe_r <= '0;       rdd_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;     pclk_r <= pclk_nxt;   st_r <= st_nxt;
      rc_r <= rc_nxt;       tmo_r <= tmo_nxt;     left_r <= left_nxt;
      q_r <= q_nxt;         stat_r <= stat_nxt;   rst_r <= rst_nxt;
      strap_r <= strap_nxt; frame_r <= frame_nxt; irdy_r <= irdy_nxt;
      bus_oe_r <= bus_oe_nxt; ad_oe_r <= ad_oe_nxt; par_r <= par_nxt;
      par_oe_r <= par_oe_nxt; idsel_r <= idsel_nxt; lock_r <= lock_nxt;
      areq_r <= areq_nxt;   dgnt_r <= dgnt_nxt;   dgh_r <= dgh_nxt;
      chk_r <= chk_nxt;     xd_r <= xd_nxt;       perr_r <= perr_nxt;
      perr_oe_r <= perr_oe_nxt; rdv_r <= rdv_nxt; done_r <= done_nxt;
      ad_r <= ad_nxt;       cbe_r <= cbe_nxt;     rdd_r <= rdd_nxt;
    end
  end

  // Pin drive; the strap moves only while bus reset is held low.
  assign pci_clk           = pclk_r;
  assign pci_rst_n         = rst_r;                      // [RULE2]
  assign host_role_strap_n = strap_r;                    // [RULE3]
  assign idsel             = idsel_r;
  assign ad_o              = ad_r;
  assign ad_oe             = ad_oe_r;
  assign cbe_n_o           = cbe_r;
  assign cbe_oe            = bus_oe_r;
  assign par_o             = par_r;
  assign par_oe            = par_oe_r;
  assign frame_n_o         = frame_r;
  assign frame_oe          = bus_oe_r;
  assign irdy_n_o          = irdy_r;
  assign irdy_oe           = bus_oe_r;
  assign lock_n_o          = !lock_r;
  assign lock_oe           = bus_oe_r;
  assign perr_n_o          = perr_r;
  assign perr_oe           = perr_oe_r;
  assign arbiter_request_in_n = ~(AGENTS'(areq_r) << AGENT_IDX);
  assign dev_gnt_n         = dgnt_r;
  assign rd_valid          = rdv_r;
  assign rd_data           = rdd_r;
  assign done              = done_r;
  assign stat              = stat_r;
endmodule : pcih_master

// [pkg/pcih_pkg.sv]
// Functional notes
// [RULE1] Sample every bus pin except reset on the rising bus-clock edge.
// [RULE2] Bus reset halts the device; it resumes after the fifth edge.
// [RULE3] Strap low selects host-bridge role; strap high selects satellite.
// [RULE4] Strap stays static; it changes only while bus reset is held.
// [RULE5] AD carries 32-bit address, then data with byte 0 in bits 7:0.
// [RULE6] C/BE carries command in address phase, byte enables in data.
// [RULE7] PAR makes ones over AD, C/BE and PAR an even count.
// [RULE8] Master drives PAR for address and write data; target for reads.
// [RULE9] FRAME asserted while more data follows, released for final phase.
// [RULE10] IRDY means write data valid or master ready to accept reads.
// [RULE11] TRDY marks target ready; a phase completes with both ready.
// [RULE12] Target STOP makes the master end the transaction.
// [RULE13] IDSEL acts as chip select for configuration accesses.
// [RULE14] DEVSEL claims the access; silence tells the master nobody answered.
// [RULE15] LOCK marks an atomic operation across a bridge.
// [RULE16] Device request output floats during bus reset.
// [RULE17] Device ignores its grant input during bus reset.
// [RULE18] Read data parity error drives PERR two clocks after the data.
// [RULE19] SERR reports catastrophic errors, driven low for one clock.
// [RULE20] Built-in arbiter takes four requests and drives matching grants.
// [RULE21] In host role with no requests, arbiter parks on agent 0.
// [RULE22] Arbiter grants one agent at a time, moving only when idle.
// =====================================================================
// Constants and carriers
package pcih_pkg;
  localparam int CORE_NS      = 25;
  localparam int PCI_NS       = 200;
  localparam int DIV          = PCI_NS / CORE_NS;
  localparam int HALF         = DIV / 2;
  localparam int CNT_W        = 4;
  localparam int RST_CLKS     = 16;
  localparam int RESUME_EDGES = 5;
  localparam int DEVSEL_TMO   = 5;
  localparam int FIFO_W       = 32;
  localparam int FIFO_D       = 16;
  localparam int AGENTS       = 4;
  localparam int AGENT_IDX    = 0;
  localparam int SYNC_W       = 44;
  localparam logic [2:0] CMD_CFG = 3'h5;

  typedef enum logic [2:0] {
    S_RST, S_WAKE, S_IDLE, S_REQ, S_ADDR, S_DATA, S_END
  } pcih_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [3:0]  be_n;
    logic [4:0]  words;
    logic        lock;
  } pcih_req_t;

  typedef struct packed {
    logic abort;
    logic stopped;
    logic perr;
    logic serr;
  } pcih_stat_t;
endpackage : pcih_pkg

// [bench/pcih_master_props.sv]
`timescale 1ns/100ps
// =====================================================================
// Port-level checks on the bus master, sampled on the core clock.
module pcih_master_props
  import pcih_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        pci_clk,
  input wire logic        pci_rst_n,
  input wire logic        host_mode,
  input wire logic        host_role_strap_n,
  input wire logic        idsel,
  input wire logic [31:0] ad_o,
  input wire logic        ad_oe,
  input wire logic [3:0]  cbe_n_o,
  input wire logic        par_o,
  input wire logic        par_oe,
  input wire logic        frame_n_o,
  input wire logic        frame_oe,
  input wire logic        irdy_n_o,
  input wire logic        irdy_oe,
  input wire logic        perr_n_o,
  input wire logic        perr_oe,
  input wire logic        done
);
  // One bus period is eight core cycles, hence the depth of 8 below.
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  chk_par_even: assert property (
    $rose(pci_clk) && par_oe |-> $past(ad_oe, 8)
      && par_o == ^{$past(ad_o, 8), $past(cbe_n_o, 8)})
    else $error("parity bit wrong");
  chk_cbe_hold: assert property (
    $rose(pci_clk) && irdy_oe && !irdy_n_o && $past(irdy_oe, 8)
      |-> cbe_n_o == $past(cbe_n_o, 8))
    else $error("byte enables moved within a transfer");
  chk_strap_fixed: assert property (
    pci_rst_n && $past(pci_rst_n) |-> $stable(host_role_strap_n))
    else $error("strap changed outside bus reset");
  chk_strap_role: assert property (
    $past(reset_n) && !pci_rst_n |=> host_role_strap_n == !$past(host_mode))
    else $error("strap does not match the chosen role");
  chk_reset_quiet: assert property (
    !pci_rst_n |-> !(ad_oe || frame_oe || irdy_oe || par_oe || perr_oe))
    else $error("bus driven during bus reset");
  chk_frame_last: assert property (
    $rose(frame_n_o) && frame_oe |-> !irdy_n_o && irdy_oe)
    else $error("frame released without ready");
  chk_idsel_cfg: assert property (
    $fell(frame_n_o) && frame_oe |-> idsel == (cbe_n_o[3:1] == CMD_CFG))
    else $error("select line wrong in address phase");
  chk_perr_pulse: assert property (
    $fell(perr_n_o) && perr_oe
      |-> (perr_oe && !perr_n_o) [*8] ##1 (perr_oe && perr_n_o))
    else $error("parity error pulse malformed");
  chk_done_free: assert property (
    done |-> !ad_oe && !frame_oe && !irdy_oe)
    else $error("bus still driven at completion");
endmodule : pcih_master_props

bind pcih_master pcih_master_props u_props (.core_clk, .reset_n,
  .pci_clk, .pci_rst_n, .host_mode, .host_role_strap_n, .idsel, .ad_o,
  .ad_oe, .cbe_n_o, .par_o, .par_oe, .frame_n_o, .frame_oe, .irdy_n_o,
  .irdy_oe, .perr_n_o, .perr_oe, .done);

// [bench/pcih_dev_model.sv]
`timescale 1ns/100ps
// =====================================================================
// Device model: a target with sixteen words of store and an arbiter.
module pcih_dev_model
  import pcih_pkg::*;
(
  input  wire logic        pci_clk,
  input  wire logic        pci_rst_n,
  input  wire logic        host_role_strap_n,
  input  wire logic        idsel,
  input  wire logic [31:0] ad_o,
  input  wire logic        ad_oe,
  input  wire logic [3:0]  cbe_n_o,
  input  wire logic        par_o,
  input  wire logic        par_oe,
  input  wire logic        frame_n_i,
  input  wire logic        irdy_n_i,
  input  wire logic        slow,
  input  wire logic        stop_req,
  input  wire logic        bad_par,
  output logic [31:0]      ad_i,
  output logic             par_i,
  output logic             trdy_n,
  output logic             devsel_n,
  output logic             stop_n,
  output logic             serr_n,
  output logic [3:0]       agnt_n,
  output logic             cfg_hit,
  output logic [31:0]      mem [16]
);
  logic [2:0]  wake;
  logic [3:0]  idx;
  logic [31:0] ad_q = '0;
  logic        act, rd, t_oe, tgl, f_q, hit;
  logic        par_t = 1'b0;
  // The grant from the master is never looked at here.
  assign hit = cbe_n_o[3:1] == CMD_CFG ? idsel : ad_i[31:28] == 4'h0;
  // Undriven data lines show the inverse of their last level.
  assign ad_i = ad_oe ? ad_o : t_oe ? mem[idx] : ~ad_q;
  assign par_i = par_oe ? par_o : par_t;
  // All lines are sampled on the rising bus-clock edge.
  always @(posedge pci_clk) begin
    ad_q <= ad_i;
    f_q <= frame_n_i;
    // A corrupted run also flags its address phase for exactly one clock.
    serr_n <= !(bad_par && !frame_n_i && f_q);
    par_t <= t_oe ? (^{ad_i, cbe_n_o}) ^ bad_par : ~par_t;
    if (host_role_strap_n) agnt_n <= 4'hf;
    else if (frame_n_i && irdy_n_i) agnt_n <= 4'he;
    if (!pci_rst_n || wake != 3'h5) begin
      wake <= pci_rst_n ? wake + 3'h1 : 3'h0;
      act <= 1'b0;
      tgl <= 1'b0;
      t_oe <= 1'b0;
      trdy_n <= 1'b1;
      devsel_n <= 1'b1;
      stop_n <= 1'b1;
    end else if (!act) begin
      if (!frame_n_i && f_q) begin
        rd <= !cbe_n_o[0];
        idx <= ad_i[5:2];
        cfg_hit <= idsel && cbe_n_o[3:1] == CMD_CFG;
        act <= hit;
        devsel_n <= !hit;
        t_oe <= hit && !cbe_n_o[0];
      end
    end else if (frame_n_i && !irdy_n_i && !(trdy_n && stop_n)) begin
      if (!rd && !trdy_n) mem[idx] <= ad_i;
      act <= 1'b0;
      t_oe <= 1'b0;
      trdy_n <= 1'b1;
      devsel_n <= 1'b1;
      stop_n <= 1'b1;
    end else begin
      if (!rd && !irdy_n_i && !trdy_n) mem[idx] <= ad_i;
      if (!irdy_n_i && !trdy_n) idx <= idx + 4'h1;
      // Ready stays asserted until a data phase completes, then drops for a clock, or longer while slow or stop_req is set.
      trdy_n <= trdy_n ? (stop_req || (slow && tgl)) : !irdy_n_i;
      stop_n <= !stop_req;
      tgl <= !tgl;
    end
  end
endmodule : pcih_dev_model

// [bench/tb_top.sv]
`timescale 1ns/100ps
// =====================================================================
// Self-checking bench around the bus master and the device model.
module tb_top
  import pcih_pkg::*;
;
  logic core_clk, reset_n, host_mode, req_valid, req_ready, wr_valid;
  logic wr_ready, rd_valid, done, pci_clk, pci_rst_n, host_role_strap_n;
  logic idsel, ad_oe, cbe_oe, par_i, par_o, par_oe, frame_n_i, frame_n_o;
  logic frame_oe, irdy_n_i, irdy_n_o, irdy_oe, trdy_n_i, devsel_n_i;
  logic stop_n_i, lock_n_o, lock_oe, perr_n_o, perr_oe, dev_gnt_n;
  logic slow, stop_req, bad_par, cfg_hit, perr_seen, serr_n_i, dev_req_n;
  logic [31:0] wr_data, rd_data, ad_i, ad_o;
  logic [31:0] mem [16];
  logic [31:0] rdq [$];
  logic [3:0]  cbe_n_o, arbiter_request_in_n, arbiter_grant_out_n;
  pcih_req_t   req;
  pcih_stat_t  stat;
  int          err_total, num_checks;

  // Released control lines float high through their pull-ups.
  assign frame_n_i = frame_oe ? frame_n_o : 1'b1;
  assign irdy_n_i = irdy_oe ? irdy_n_o : 1'b1;

  // The device's own request floats in reset, so the bench holds it high.
  pcih_master #(.RST_LEN(2)) DUT (.core_clk, .reset_n, .host_mode,
    .req_valid, .req_ready, .req, .wr_valid, .wr_ready, .wr_data, .rd_valid,
    .rd_data, .done, .stat, .pci_clk, .pci_rst_n, .host_role_strap_n,
    .idsel, .ad_i, .ad_o, .ad_oe, .cbe_n_o, .cbe_oe, .par_i, .par_o,
    .par_oe, .frame_n_i, .frame_n_o, .frame_oe, .irdy_n_i, .irdy_n_o,
    .irdy_oe, .trdy_n_i, .devsel_n_i, .stop_n_i, .lock_n_o, .lock_oe,
    .perr_n_o, .perr_oe, .serr_n_i, .arbiter_request_in_n,
    .arbiter_grant_out_n, .dev_req_n_i(dev_req_n), .dev_gnt_n);
  pcih_dev_model dev (.pci_clk, .pci_rst_n, .host_role_strap_n, .idsel,
    .ad_o, .ad_oe, .cbe_n_o, .par_o, .par_oe, .frame_n_i, .irdy_n_i,
    .slow, .stop_req, .bad_par, .ad_i, .par_i, .trdy_n(trdy_n_i),
    .devsel_n(devsel_n_i), .stop_n(stop_n_i), .agnt_n(arbiter_grant_out_n),
    .cfg_hit, .mem, .serr_n(serr_n_i));

  // Collect read words and parity-error pulses as they appear.
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (perr_oe && !perr_n_o) perr_seen <= 1'b1;
  end

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // A wait that ran out of cycles counts against the run and ends it.
  task automatic hang();
    err_total++;
    give_verdict();
  endtask : hang

  task automatic do_reset(input logic hm);
    int n;
    reset_n = 1'b0;
    host_mode = hm;
    repeat (2) @(negedge core_clk);
    check({pci_rst_n, ad_oe, frame_oe, arbiter_request_in_n[0]}, 4'h1);
    check(dev_gnt_n, 1'b1);
    reset_n = 1'b1;
    for (n = 0; n < 400 && req_ready !== 1'b1; n++) @(negedge core_clk);
    if (n == 400) hang();
    check(host_role_strap_n, !hm);
    // Only the satellite role lets this end grant the device the bus.
    dev_req_n = hm;
    repeat (24) @(negedge core_clk);
    check(dev_gnt_n, hm);
    dev_req_n = 1'b1;
    $display("reset test done");
  endtask : do_reset

  task automatic push(input int cnt, input logic [31:0] base);
    int i;
    int n;
    wr_valid = 1'b1;
    for (i = 0; i < cnt; i++) begin
      wr_data = base + i;
      for (n = 0; n < 200 && wr_ready !== 1'b1; n++) @(negedge core_clk);
      if (n == 200) hang();
      @(negedge core_clk);
    end
    wr_valid = 1'b0;
  endtask : push

  task automatic run(input logic [31:0] a, input logic [3:0] c,
                     input logic [4:0] w, input logic [3:0] st);
    int n;
    req = '{addr: a, cmd: c, be_n: 4'h0, words: w, lock: 1'b0};
    req_valid = 1'b1;
    for (n = 0; n < 400 && req_ready !== 1'b1; n++) @(negedge core_clk);
    if (n == 400) hang();
    @(negedge core_clk);
    req_valid = 1'b0;
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge core_clk);
    if (n == 3000) hang();
    check(stat, st);
  endtask : run

  // A full buffer refuses, then drains into a slow target.
  task automatic t_write();
    push(16, 32'ha5a5_0000);
    wr_valid = 1'b1;
    @(negedge core_clk);
    check(wr_ready, 1'b0);
    wr_valid = 1'b0;
    slow = 1'b1;
    run(32'h0000_0000, 4'h7, 5'h10, 4'h0);
    for (int i = 0; i < 16; i++) check(mem[i], 32'ha5a5_0000 + i);
    check(wr_ready, 1'b1);
    slow = 1'b0;
    $display("write burst test done");
  endtask : t_write

  task automatic t_read();
    rdq.delete();
    run(32'h0000_0008, 4'h6, 5'h03, 4'h0);
    check(rdq.size(), 3);
    for (int i = 0; i < 3; i++) check(rdq[i], 32'ha5a5_0002 + i);
    $display("read burst test done");
  endtask : t_read

  task automatic t_errors();
    run(32'h8000_0004, 4'ha, 5'h01, 4'h0);
    check(cfg_hit, 1'b1);
    bad_par = 1'b1;
    perr_seen = 1'b0;
    run(32'h0000_0000, 4'h6, 5'h01, 4'h3);
    repeat (40) @(negedge core_clk);
    check(perr_seen, 1'b1);
    bad_par = 1'b0;
    run(32'h8000_0000, 4'h6, 5'h01, 4'h8);
    push(1, 32'h1234_5678);
    stop_req = 1'b1;
    // Two words, so the stop arrives while more data is still due.
    run(32'h0000_0000, 4'h7, 5'h02, 4'h4);
    check(mem[0], 32'ha5a5_0000);
    stop_req = 1'b0;
    $display("error paths test done");
  endtask : t_errors

  initial begin
    {reset_n, host_mode, req_valid, wr_valid, slow, stop_req} = '0;
    {bad_par, perr_seen} = '0;
    dev_req_n = 1'b1;
    req = '0;
    wr_data = '0;
    err_total = 0;
    num_checks = 0;
    do_reset(1'b0);
    do_reset(1'b1);
    t_write();
    t_read();
    t_errors();
    give_verdict();
  end
endmodule : tb_top
